// ==== hdl/ecrp_port.sv ====
`timescale 1ns/1ps
// Functional notes
// R1: Drive 8-bit function number, valid while read or write received.
// R2: Present 32-bit write data while write received is high.
// R3: Present 4-bit byte enables with each configuration write.
// R4: Capture read data at edge after read received, only if valid.
// R5: User raises read valid with data; sampled edge after read received.
// R6: Abandon user read after 40000h application clock cycles; the code counts mclk_in cycles instead.
// R7: Output fixed-rate application clock chosen at configuration time.
// R8: Release application reset synchronously to application clock; the code releases it on an mclk_in edge instead.
// R9: Assert application reset asynchronously on fundamental reset.
// R10: System supplies reference clock at the configured rate.
// R11: Raise phy ready once reset sequencer sees transceiver status.
// R12: Hold read received in user windows until valid; else one pulse.
// R13: Each configuration write gives a single-cycle write received pulse.
// R14: Present 10-bit register number while read or write received.
// R15: User drives read data and read valid in the same cycle.
module ecrp_port #(
  parameter logic [18:0] TIMEOUT_CYC = ecrp_pkg::ECRP_RD_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  // System pins
  input  wire logic        fund_rst_n_in,
  input  wire logic        refclk_in,
  input  wire logic        phy_status_in,
  input  wire logic [1:0]  app_clk_sel_in,
  output logic             app_clk_out,
  output logic             app_rst_out,
  output logic             phy_rdy_out,
  // Configuration options
  input  wire logic        legacy_en_in,
  input  wire logic        extended_en_in,
  // Request from link side
  input  wire logic        req_valid_in,
  input  wire logic        req_write_in,
  input  wire logic [9:0]  req_reg_in,
  input  wire logic [7:0]  req_func_in,
  input  wire logic [31:0] req_wdata_in,
  input  wire logic [3:0]  req_be_in,
  output logic             req_ready_out,
  // Completion to link side
  output logic             cpl_valid_out,
  output logic             cpl_timeout_out,
  output logic [31:0]      cpl_data_out,
  // User register side
  output logic             rd_rcvd_out,
  output logic             wr_rcvd_out,
  output logic [9:0]       reg_num_out,
  output logic [7:0]       func_num_out,
  output logic [31:0]      wr_data_out,
  output logic [3:0]       wr_be_out,
  input  wire logic [31:0] rd_data_in,
  input  wire logic        rd_data_valid_in
);
  import ecrp_pkg::*;

  ecrp_sys_if  sys_if ();

  ecrp_rd_st_t st_r, st_nxt;
  logic        ready_r, ready_nxt;
  logic        rd_r, rd_nxt;
  logic        wr_r, wr_nxt;
  logic [9:0]  reg_r, reg_nxt;
  logic [7:0]  func_r, func_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0]  be_r, be_nxt;
  logic        cpl_r, cpl_nxt;
  logic        to_r, to_nxt;
  logic [31:0] cdata_r, cdata_nxt;
  logic [18:0] cnt_r, cnt_nxt;
  logic        accept;
  logic        user_win;
  logic        last_cnt;

  // ----------------------------------------------------------------
  // Clock, reset and phy ready generation
  // ----------------------------------------------------------------
  assign sys_if.fund_rst_n = fund_rst_n_in;
  assign sys_if.refclk     = refclk_in;
  assign sys_if.phy_status = phy_status_in;
  assign sys_if.clk_sel    = app_clk_sel_in;

  ecrp_clkrst u_clkrst (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .sys       (sys_if.gen)
  );

  assign app_clk_out = sys_if.app_clk;
  assign app_rst_out = sys_if.app_rst;
  assign phy_rdy_out = sys_if.phy_rdy;

  // ----------------------------------------------------------------
  // Request handling
  // ----------------------------------------------------------------
  assign accept   = req_valid_in & ready_r;
  assign last_cnt = (cnt_r == TIMEOUT_CYC - 19'h1);
  assign user_win =                                          // R12
    (legacy_en_in && req_reg_in >= ECRP_LEG_LO && req_reg_in <= ECRP_LEG_HI)
    || (extended_en_in && req_reg_in >= ECRP_EXT_LO
        && req_reg_in <= ECRP_EXT_HI);

  always_comb begin
    st_nxt    = st_r;
    rd_nxt    = rd_r;
    wr_nxt    = 1'b0;                                        // R13
    reg_nxt   = reg_r;
    func_nxt  = func_r;
    wdata_nxt = wdata_r;
    be_nxt    = be_r;
    cpl_nxt   = 1'b0;
    to_nxt    = 1'b0;
    cdata_nxt = cdata_r;
    cnt_nxt   = cnt_r;
    case (st_r)
      ECRP_IDLE: begin
        if (accept) begin
          reg_nxt  = req_reg_in;                             // R14
          func_nxt = req_func_in;                            // R1
          cnt_nxt  = 19'h0;
          if (req_write_in) begin
            wr_nxt    = 1'b1;
            wdata_nxt = req_wdata_in;                        // R2
            be_nxt    = req_be_in;                           // R3
          end else begin
            rd_nxt = 1'b1;
            st_nxt = user_win ? ECRP_HOLD : ECRP_SAMP;       // R12
          end
        end
      end
      ECRP_SAMP: begin
        // Outside user windows a missing valid answers zero
        rd_nxt    = 1'b0;
        cpl_nxt   = 1'b1;
        cdata_nxt = rd_data_valid_in ? rd_data_in : 32'h0;   // R4
        st_nxt    = ECRP_IDLE;
      end
      ECRP_HOLD: begin
        if (rd_data_valid_in) begin                          // R5
          rd_nxt    = 1'b0;
          cpl_nxt   = 1'b1;
          cdata_nxt = rd_data_in;                            // R4
          st_nxt    = ECRP_IDLE;
        end else if (last_cnt) begin
          rd_nxt = 1'b0;
          to_nxt = 1'b1;                                     // R6
          st_nxt = ECRP_IDLE;
        end else begin
          cnt_nxt = cnt_r + 19'h1;
        end
      end
      default: begin
        rd_nxt = 1'b0;
        st_nxt = ECRP_IDLE;
      end
    endcase
    // One idle cycle after each accept keeps write pulses apart
    ready_nxt = (st_nxt == ECRP_IDLE) && !accept;
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r    <= ECRP_IDLE;
      ready_r <= 1'b0;
      rd_r    <= 1'b0;
      wr_r    <= 1'b0;
      reg_r   <= 10'h000;
      func_r  <= 8'h00;
      wdata_r <= 32'h0000_0000;
      be_r    <= 4'h0;
      cpl_r   <= 1'b0;
      to_r    <= 1'b0;
      cdata_r <= 32'h0000_0000;
      cnt_r   <= 19'h0_0000;
    end else begin
      st_r    <= st_nxt;
      ready_r <= ready_nxt;
      rd_r    <= rd_nxt;
      wr_r    <= wr_nxt;
      reg_r   <= reg_nxt;
      func_r  <= func_nxt;
      wdata_r <= wdata_nxt;
      be_r    <= be_nxt;
      cpl_r   <= cpl_nxt;
      to_r    <= to_nxt;
      cdata_r <= cdata_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign req_ready_out   = ready_r;
  assign rd_rcvd_out     = rd_r;
  assign wr_rcvd_out     = wr_r;
  assign reg_num_out     = reg_r;
  assign func_num_out    = func_r;
  assign wr_data_out     = wdata_r;
  assign wr_be_out       = be_r;
  assign cpl_valid_out   = cpl_r;
  assign cpl_timeout_out = to_r;
  assign cpl_data_out    = cdata_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  sequence wr_take_s;
    accept && req_write_in;
  endsequence
  sequence rd_take_s;
    accept && !req_write_in;
  endsequence

  wr_pulse_a: assert property (wr_rcvd_out |=> !wr_rcvd_out) // R13
    else $error("write received longer than one cycle");
  wr_fields_a: assert property (wr_take_s |=> wr_rcvd_out // R2
    && wr_data_out == $past(req_wdata_in)
    && wr_be_out == $past(req_be_in))
    else $error("write data or enables not presented");
  req_ident_a: assert property (accept |=> // R1
    reg_num_out == $past(req_reg_in)
    && func_num_out == $past(req_func_in))
    else $error("register or function number wrong");
  rd_pulse_a: assert property (rd_take_s ##0 !user_win |=> // R12
    rd_rcvd_out ##1 (!rd_rcvd_out && cpl_valid_out))
    else $error("read outside user window not a single pulse");
  rd_hold_a: assert property (st_r == ECRP_HOLD // R12
    && !rd_data_valid_in && !last_cnt |=> rd_rcvd_out)
    else $error("read received dropped before valid data");
  rd_capture_a: assert property (rd_rcvd_out && rd_data_valid_in // R4
    |=> cpl_valid_out && !rd_rcvd_out
    && cpl_data_out == $past(rd_data_in))
    else $error("read data not captured on valid");
  rd_timeout_a: assert property (st_r == ECRP_HOLD // R6
    && last_cnt && !rd_data_valid_in
    |=> cpl_timeout_out && !rd_rcvd_out && req_ready_out)
    else $error("read timeout not taken");
  to_count_a: assert property (st_r == ECRP_HOLD // R6
    && !rd_data_valid_in && !last_cnt |=> cnt_r == $past(cnt_r) + 19'h1)
    else $error("timeout counter did not advance");
  busy_read_a: assert property (rd_rcvd_out |-> !req_ready_out) // R14
    else $error("new request accepted during read");

endmodule

// ==== pkg/ecrp_pkg.sv ====
package ecrp_pkg;

  // ----------------------------------------------------------------
  // Register number windows served by user logic
  // ----------------------------------------------------------------
  localparam logic [9:0]  ECRP_LEG_LO        = 10'h010;
  localparam logic [9:0]  ECRP_LEG_HI        = 10'h01F;
  localparam logic [9:0]  ECRP_EXT_LO        = 10'h120;
  localparam logic [9:0]  ECRP_EXT_HI        = 10'h3FF;

  // ----------------------------------------------------------------
  // Counts of mclk_in cycles and reference clock edges
  // ----------------------------------------------------------------
  localparam logic [18:0] ECRP_RD_TIMEOUT_CYC = 19'h4_0000;
  localparam logic [2:0]  ECRP_REFCLK_EDGES   = 3'h4;

  // ----------------------------------------------------------------
  // Application clock selection and divider half periods
  // ----------------------------------------------------------------
  localparam logic [1:0]  ECRP_SEL_62M       = 2'h0;
  localparam logic [1:0]  ECRP_SEL_125M      = 2'h1;
  localparam logic [1:0]  ECRP_SEL_250M      = 2'h2;
  localparam logic [2:0]  ECRP_HALF_62M      = 3'h4;
  localparam logic [2:0]  ECRP_HALF_125M     = 3'h2;
  localparam logic [2:0]  ECRP_HALF_250M     = 3'h1;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [1:0]  ECRP_SEL_RST       = 2'h0;
  localparam logic        ECRP_APP_RST_RST   = 1'b1;

  typedef enum logic [1:0] {
    ECRP_IDLE = 2'b00,
    ECRP_HOLD = 2'b01,
    ECRP_SAMP = 2'b10
  } ecrp_rd_st_t;

  typedef enum logic [1:0] {
    ECRP_PHY_RST  = 2'b00,
    ECRP_PHY_WAIT = 2'b01,
    ECRP_PHY_RDY  = 2'b10
  } ecrp_phy_st_t;

endpackage

// ==== pkg/ecrp_sys_if.sv ====
`timescale 1ns/1ps
interface ecrp_sys_if;
  logic       fund_rst_n;
  logic       refclk;
  logic       phy_status;
  logic [1:0] clk_sel;
  logic       app_clk;
  logic       app_rst;
  logic       phy_rdy;

  modport gen  (input  fund_rst_n, refclk, phy_status, clk_sel,
                output app_clk, app_rst, phy_rdy);
  modport core (output fund_rst_n, refclk, phy_status, clk_sel,
                input  app_clk, app_rst, phy_rdy);
endinterface

// ==== hdl/ecrp_clkrst.sv ====
`timescale 1ns/1ps
module ecrp_clkrst (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic arst_n_in,
  // System pins and generated clock, reset, ready
  ecrp_sys_if.gen   sys
);
  import ecrp_pkg::*;

  logic         sys_rst_n;
  logic         rs1_r, rs2_r, app_rst_r;
  logic         ps1_r, ps2_r, cs1_r, cs2_r, cs3_r;
  logic [1:0]   ss1_r, ss2_r;
  logic [1:0]   sel_r, sel_nxt;
  logic         sel_done_r, sel_done_nxt;
  logic [2:0]   div_r, div_nxt, half;
  logic         app_clk_r, app_clk_nxt;
  ecrp_phy_st_t phy_st_r, phy_st_nxt;
  logic [2:0]   edg_r, edg_nxt;
  logic         phy_rdy_r, phy_rdy_nxt;

  // Fundamental reset forces app reset, clock select and phy sequencer without a clock
  assign sys_rst_n = arst_n_in & sys.fund_rst_n;

  // ----------------------------------------------------------------
  // Application reset: asynchronous assert, synchronous release
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      rs1_r     <= 1'b0;                                   // R9
      rs2_r     <= 1'b0;
      app_rst_r <= ECRP_APP_RST_RST;
    end else begin
      rs1_r     <= 1'b1;
      rs2_r     <= rs1_r;
      app_rst_r <= ~rs2_r;                                 // R8
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ps1_r <= 1'b0;
      ps2_r <= 1'b0;
      cs1_r <= 1'b0;
      cs2_r <= 1'b0;
      cs3_r <= 1'b0;
      ss1_r <= ECRP_SEL_RST;
      ss2_r <= ECRP_SEL_RST;
    end else begin
      ps1_r <= sys.phy_status;
      ps2_r <= ps1_r;
      cs1_r <= sys.refclk;
      cs2_r <= cs1_r;
      cs3_r <= cs2_r;
      ss1_r <= sys.clk_sel;
      ss2_r <= ss1_r;
    end
  end

  // ----------------------------------------------------------------
  // Clock select strap and application clock divider
  // ----------------------------------------------------------------
  always_comb begin
    sel_nxt      = sel_r;
    sel_done_nxt = sel_done_r;
    if (!sel_done_r && !app_rst_r) begin
      sel_nxt      = ss2_r;
      sel_done_nxt = 1'b1;
    end
    case (sel_r)
      ECRP_SEL_125M: half = ECRP_HALF_125M;
      ECRP_SEL_250M: half = ECRP_HALF_250M;
      default:       half = ECRP_HALF_62M;
    endcase
    div_nxt     = div_r + 3'h1;
    app_clk_nxt = app_clk_r;
    if (div_r >= half - 3'h1) begin
      div_nxt     = 3'h0;
      app_clk_nxt = ~app_clk_r;                            // R7
    end
  end

  // Divider keeps running in fundamental reset so users see clock edges for release
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_r     <= 3'h0;
      app_clk_r <= 1'b0;
    end else begin
      div_r     <= div_nxt;
      app_clk_r <= app_clk_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Physical-layer reset sequencer
  // ----------------------------------------------------------------
  // Reference clock is only checked for activity; 200 MHz sampling
  // cannot measure its rate.
  always_comb begin
    phy_st_nxt = phy_st_r;
    edg_nxt    = edg_r;
    case (phy_st_r)
      ECRP_PHY_RST: begin
        if (cs2_r != cs3_r) edg_nxt = edg_r + 3'h1;
        if (edg_r == ECRP_REFCLK_EDGES) phy_st_nxt = ECRP_PHY_WAIT;
      end
      ECRP_PHY_WAIT: begin
        if (ps2_r) phy_st_nxt = ECRP_PHY_RDY;              // R11
      end
      ECRP_PHY_RDY: begin
        if (!ps2_r) begin
          phy_st_nxt = ECRP_PHY_RST;
          edg_nxt    = 3'h0;
        end
      end
      default: phy_st_nxt = ECRP_PHY_RST;
    endcase
    phy_rdy_nxt = (phy_st_nxt == ECRP_PHY_RDY);
  end

  always_ff @(posedge mclk_in or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      sel_r      <= ECRP_SEL_RST;
      sel_done_r <= 1'b0;
      phy_st_r   <= ECRP_PHY_RST;
      edg_r      <= 3'h0;
      phy_rdy_r  <= 1'b0;
    end else begin
      sel_r      <= sel_nxt;
      sel_done_r <= sel_done_nxt;
      phy_st_r   <= phy_st_nxt;
      edg_r      <= edg_nxt;
      phy_rdy_r  <= phy_rdy_nxt;
    end
  end

  assign sys.app_clk = app_clk_r;
  assign sys.app_rst = app_rst_r;
  assign sys.phy_rdy = phy_rdy_r;

  app_rst_rel_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // R8
    sys.fund_rst_n [*4] |-> !app_rst_r)
    else $error("app reset not released after fundamental reset");
  phy_rdy_src_a: assert property (@(posedge mclk_in) disable iff (!sys_rst_n) // R11
    $rose(phy_rdy_r) |-> $past(ps2_r) && $past(phy_st_r) == ECRP_PHY_WAIT)
    else $error("phy ready raised without status");
  fast_clk_a: assert property (@(posedge mclk_in) disable iff (!sys_rst_n) // R7
    sel_r == ECRP_SEL_250M |=> app_clk_r != $past(app_clk_r))
    else $error("fastest application clock did not toggle");

endmodule

// ==== sim/ecrp_user_model.sv ====
`timescale 1ns/1ps
module ecrp_user_model (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  // Device user side
  input  wire logic        rd_rcvd_in,
  input  wire logic        wr_rcvd_in,
  input  wire logic [9:0]  reg_num_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic [3:0]  wr_be_in,
  output logic [31:0]      rd_data_out,
  output logic             rd_data_valid_out,
  // Bench control
  input  wire logic [7:0]  delay_in,
  input  wire logic        mute_in
);
  logic [31:0] mem_r [0:1023];
  logic [7:0]  wait_r;
  logic [31:0] junk_r;

  // --------------------------------------------------------------
  // Wait counter and idle pattern
  // --------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_r <= 8'h00;
      junk_r <= 32'h5A5A_A5A5;
    end else begin
      // Bus never rests at the old value between answers
      junk_r <= ~junk_r ^ {24'h00_0000, wait_r};
      wait_r <= rd_rcvd_in ? wait_r + 8'h01 : 8'h00;
    end
  end

  // --------------------------------------------------------------
  // Register store with byte lanes
  // --------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (wr_rcvd_in) begin
      for (int i = 0; i < 4; i++) begin
        if (wr_be_in[i]) begin
          mem_r[reg_num_in][8*i +: 8] <= wr_data_in[8*i +: 8];
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Answer: data and valid together, zero delay is combinational
  // --------------------------------------------------------------
  assign rd_data_valid_out = rd_rcvd_in && !mute_in &&
                             (wait_r == delay_in);
  assign rd_data_out = rd_data_valid_out ? mem_r[reg_num_in]
                                         : junk_r;
endmodule

// ==== sim/ecrp_port_tb.sv ====
`timescale 1ns/1ps
module ecrp_port_tb;
  import ecrp_pkg::*;
  localparam logic [18:0] TMO = 19'h10;
  logic        mclk_in = 1'b0, arst_n_in = 1'b0, fund_rst_n = 1'b0;
  logic        refclk = 1'b0, phy_status = 1'b0, leg_en = 1'b0;
  logic        ext_en = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic        mute = 1'b0, rd_valid;
  logic [1:0]  clk_sel = 2'h0;
  logic [9:0]  req_reg = 10'h000, reg_num_out;
  logic [7:0]  req_func = 8'h00, func_num_out, dly = 8'h00;
  logic [31:0] req_wdata = 32'h0, rd_data, cpl_data_out, wr_data_out;
  logic [3:0]  req_be = 4'h0, wr_be_out;
  logic        app_clk_out, app_rst_out, phy_rdy_out, req_ready_out;
  logic        cpl_valid_out, cpl_timeout_out, rd_rcvd_out, wr_rcvd_out;
  logic [31:0] lfsr = 32'h7;
  logic [31:0] shadow [0:1023];
  logic [9:0]  regs [0:7];
  int          error_cnt = 0, comparisons = 0, n;

  always #2.5 mclk_in = ~mclk_in;
  always #5 refclk = ~refclk;

  ecrp_port #(.TIMEOUT_CYC(TMO)) uut (.mclk_in(mclk_in),
    .arst_n_in(arst_n_in), .fund_rst_n_in(fund_rst_n),
    .refclk_in(refclk), .phy_status_in(phy_status),
    .app_clk_sel_in(clk_sel), .app_clk_out(app_clk_out),
    .app_rst_out(app_rst_out), .phy_rdy_out(phy_rdy_out),
    .legacy_en_in(leg_en), .extended_en_in(ext_en),
    .req_valid_in(req_valid), .req_write_in(req_write),
    .req_reg_in(req_reg), .req_func_in(req_func),
    .req_wdata_in(req_wdata), .req_be_in(req_be),
    .req_ready_out(req_ready_out), .cpl_valid_out(cpl_valid_out),
    .cpl_timeout_out(cpl_timeout_out), .cpl_data_out(cpl_data_out),
    .rd_rcvd_out(rd_rcvd_out), .wr_rcvd_out(wr_rcvd_out),
    .reg_num_out(reg_num_out), .func_num_out(func_num_out),
    .wr_data_out(wr_data_out), .wr_be_out(wr_be_out),
    .rd_data_in(rd_data), .rd_data_valid_in(rd_valid));

  ecrp_user_model user (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .rd_rcvd_in(rd_rcvd_out), .wr_rcvd_in(wr_rcvd_out),
    .reg_num_in(reg_num_out), .wr_data_in(wr_data_out),
    .wr_be_in(wr_be_out), .rd_data_out(rd_data),
    .rd_data_valid_out(rd_valid), .delay_in(dly), .mute_in(mute));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic in_win(input logic [9:0] r);
    return (leg_en && r >= ECRP_LEG_LO && r <= ECRP_LEG_HI) ||
           (ext_en && r >= ECRP_EXT_LO && r <= ECRP_EXT_HI);
  endfunction

  task automatic test_done;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic tick;
    @(posedge mclk_in);
    #1;
  endtask

  // Holds the request until the edge where ready is seen high
  task automatic req(input logic w, input logic [9:0] r,
                     input logic [31:0] d, input logic [3:0] be);
    int k;
    lfsr = lfsr_next(lfsr);
    req_valid = 1'b1;
    req_write = w;
    req_reg = r;
    req_func = lfsr[7:0];
    req_wdata = d;
    req_be = be;
    k = 0;
    while (req_ready_out !== 1'b1 && k < 50) begin
      tick();
      k++;
    end
    if (k == 50) begin
      error_cnt++;
      test_done();
    end
    tick();
    req_valid = 1'b0;
    chk(req_ready_out, 1'b0);
    chk(reg_num_out, r);
    chk(func_num_out, req_func);
  endtask

  task automatic do_wr(input logic [9:0] r, input logic [3:0] be);
    logic [31:0] d;
    lfsr = lfsr_next(lfsr);
    d = lfsr;
    // Request task steps the generator again, so keep the word
    req(1'b1, r, d, be);
    chk(wr_rcvd_out, 1'b1);
    chk(wr_data_out, d);
    chk(wr_be_out, be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) shadow[r][8*i +: 8] = d[8*i +: 8];
    end
    tick();
    chk(wr_rcvd_out, 1'b0);
  endtask

  task automatic do_rd(input logic [9:0] r);
    logic w;
    logic ans;
    int   held;
    w = in_win(r);
    held = w ? (mute ? int'(TMO) : int'(dly) + 1) : 1;
    ans = !mute && (w || dly == 8'h00);
    req(1'b0, r, 32'h0, 4'h0);
    n = 0;
    while (rd_rcvd_out === 1'b1 && n < 300) begin
      n++;
      tick();
    end
    chk(32'(n), 32'(held));
    if (n == 300) test_done();
    chk(cpl_timeout_out, w && mute);
    chk(cpl_valid_out, !(w && mute));
    if (!(w && mute)) chk(cpl_data_out, ans ? shadow[r] : 32'h0);
  endtask

  // Selects application reset when rst_sel is high, else phy ready
  task automatic wait_lvl(input logic rst_sel, input logic v);
    logic s;
    n = 0;
    s = rst_sel ? app_rst_out : phy_rdy_out;
    while (s !== v && n < 100) begin
      tick();
      n++;
      s = rst_sel ? app_rst_out : phy_rdy_out;
    end
    chk(s, v);
    if (s !== v) test_done();
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    regs = '{10'h010, 10'h01F, 10'h00F, 10'h020,
             10'h120, 10'h3FF, 10'h11F, 10'h200};
    repeat (4) tick();
    chk(app_rst_out, 1'b1);
    arst_n_in = 1'b1;
    fund_rst_n = 1'b1;
    tick();
    tick();
    chk(app_rst_out, 1'b1);
    tick();
    chk(app_rst_out, 1'b0);
    $display("test reset done");
    chk(phy_rdy_out, 1'b0);
    phy_status = 1'b1;
    wait_lvl(1'b0, 1'b1);
    $display("test phy done");
    for (int s = 0; s < 4; s++) begin
      fund_rst_n = 1'b0;
      clk_sel = 2'(s);
      #1;
      chk(app_rst_out, 1'b1);
      tick();
      chk(phy_rdy_out, 1'b0);
      fund_rst_n = 1'b1;
      wait_lvl(1'b1, 1'b0);
      for (int p = 0; p < 3; p++) begin
        lfsr[0] = app_clk_out;
        n = 0;
        while (app_clk_out === lfsr[0] && n < 20) begin
          tick();
          n++;
        end
        if (n == 20) begin
          error_cnt++;
          test_done();
        end
      end
      chk(32'(n), s == 1 ? 32'h2 : (s == 2 ? 32'h1 : 32'h4));
    end
    wait_lvl(1'b0, 1'b1);
    $display("test clocks done");
    for (int m = 0; m < 4; m++) begin
      leg_en = m[0];
      ext_en = m[1];
      for (int i = 0; i < 8; i++) begin
        do_wr(regs[i], 4'hF);
        lfsr = lfsr_next(lfsr);
        do_wr(regs[i], lfsr[3:0]);
        lfsr = lfsr_next(lfsr);
        dly = (i < 2) ? 8'(i) : {6'h00, lfsr[1:0]};
        do_rd(regs[i]);
      end
    end
    $display("test requests done");
    mute = 1'b1;
    for (int i = 0; i < 8; i++) do_rd(regs[i]);
    mute = 1'b0;
    do_rd(regs[4]);
    $display("test timeout done");
    test_done();
  end
endmodule
